/* mapc_cfg.svh */
`ifndef MAPC_CFG_SVH
`define MAPC_CFG_SVH

// address ball count and bank select width
`define MAPC_ADDR_W 22
`define MAPC_BANK_W 3

// ball positions on the shared address balls
`define MAPC_BALL_0 0
`define MAPC_BALL_3 3
`define MAPC_BALL_4 4
`define MAPC_BALL_5 5
`define MAPC_BALL_8 8
`define MAPC_BALL_9 9
`define MAPC_BALL_10 10
`define MAPC_BALL_13 13
`define MAPC_BALL_14 14
`define MAPC_BALL_17 17
`define MAPC_BALL_18 18

// address bit positions filled from the second part
`define MAPC_BIT_1 1
`define MAPC_BIT_2 2
`define MAPC_BIT_6 6
`define MAPC_BIT_7 7
`define MAPC_BIT_11 11
`define MAPC_BIT_12 12
`define MAPC_BIT_15 15
`define MAPC_BIT_16 16
`define MAPC_BIT_19 19
`define MAPC_BIT_20 20
`define MAPC_BIT_21 21

// mode register field positions within the assembled address
`define MAPC_MR_CFG_LSB 0
`define MAPC_MR_BL_LSB 3
`define MAPC_MR_MUX_BIT 5
`define MAPC_MR_DLL_BIT 7
`define MAPC_MR_IMP_BIT 8
`define MAPC_MR_ODT_BIT 9

// mode register reset values
`define MAPC_CFG_RST 3'h1
`define MAPC_BL_RST 2'h0
`define MAPC_BIT_RST 1'h0

// row cycle clocks per configuration
`define MAPC_RC_CFG1 4'h4
`define MAPC_RC_CFG2 4'h6
`define MAPC_RC_CFG3 4'h8
`define MAPC_RC_CFG4 4'h3
`define MAPC_RC_CFG5 4'h5

// latency offsets over the row cycle
`define MAPC_RL_OVER_RC 4'h0
`define MAPC_WL_OVER_RL 4'h1
`define MAPC_MUX_EXTRA 4'h1

`endif

/* mapc_ctrl_model.sv */
`timescale 1ns/1ps
// memory controller model on the far side of the command port
module mapc_ctrl_model (
  // clock
  input wire logic clk,
  // command and address pins toward the port
  output logic cs_n,
  output logic we_n,
  output logic ref_n,
  output logic [2:0] bank,
  output logic [21:0] addr
);
  // deselected and quiet from time zero
  initial begin
    cs_n = 1'b1;
    we_n = 1'b1;
    ref_n = 1'b1;
    bank = 3'h0;
    addr = 22'h000000;
  end
  // one command edge, driven from the falling edge
  task automatic issue(input logic we, input logic rf, input logic [2:0] bk,
      input logic [21:0] a);
    @(negedge clk);
    cs_n <= 1'b0;
    we_n <= we;
    ref_n <= rf;
    bank <= bk;
    addr <= a;
  endtask
  // second address part; pins look like a mode set, which must be ignored
  task automatic part2(input logic [21:0] a);
    @(negedge clk);
    we_n <= 1'b0;
    ref_n <= 1'b0;
    bank <= ~bank;
    addr <= a;
  endtask
  // deselected cycles; released balls toggle so stale values never match
  task automatic rest(input int n);
    repeat (n) begin
      @(negedge clk);
      cs_n <= 1'b1;
      addr <= ~addr;
      bank <= ~bank;
    end
  endtask
endmodule

/* mapc_pkg.sv */
package mapc_pkg;

  // command decoded from the select, write and refresh pins
  typedef enum logic [1:0] {
    MAPC_CMD_READ = 2'h0,
    MAPC_CMD_WRITE = 2'h1,
    MAPC_CMD_REFRESH = 2'h2,
    MAPC_CMD_MODE = 2'h3
  } mapc_cmd_e;

  // data width strap
  typedef enum logic [1:0] {
    MAPC_W_X9 = 2'h0,
    MAPC_W_X18 = 2'h1,
    MAPC_W_X36 = 2'h2
  } mapc_width_e;

  // burst length field
  typedef enum logic [1:0] {
    MAPC_BL_2 = 2'h0,
    MAPC_BL_4 = 2'h1,
    MAPC_BL_8 = 2'h2
  } mapc_bl_e;

  // capture state
  typedef enum logic {
    MAPC_ST_IDLE = 1'b0,
    MAPC_ST_SECOND = 1'b1
  } mapc_state_e;

  // command handed to the array core
  typedef struct packed {
    logic valid;
    mapc_cmd_e kind;
    logic [2:0] bank;
    logic [21:0] addr;
  } mapc_cmd_s;

  // timing presented to the array core
  typedef struct packed {
    logic [2:0] config_sel;
    mapc_bl_e burst_length;
    logic [3:0] row_cycle_time;
    logic [3:0] read_latency_clocks;
    logic [3:0] write_latency_clocks;
  } mapc_timing_s;

endpackage

/* mapc_port.sv */
`timescale 1ns/1ps
`include "mapc_cfg.svh"
// Contract
// - MODE_REGISTER_SET_CMD with A5 high enters multiplexed mode
// - DLL reset turns DLL off; bank ignored
// - burst eight refused in configurations 1, 4
// - two address parts share the same balls
// - width/burst exceptions for A20, A21, A18
// - multiplexed mode adds one latency clock
// - five configurations give fixed row/read/write clocks
// - refresh in multiplexed mode executes on the following edge; single-part refresh issues on its own edge
// - command accepted right after a refresh
module mapc_port import mapc_pkg::*; (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // command pins, active low
  input wire logic CS_N,
  input wire logic WE_N,
  input wire logic REF_N,
  // bank and address balls
  input wire logic [2:0] BANK_SEL,
  input wire logic [21:0] ADDR_BALL,
  // data width strap
  input wire logic [1:0] WIDTH_STRAP,
  // decoded command and timing
  output mapc_cmd_s CMD_OUT,
  output mapc_timing_s TIMING_OUT,
  // mode status
  output logic MUX_MODE,
  output logic DLL_OFF,
  output logic BURST_REJECT,
  output logic DRIVE_IMP,
  output logic TERM_ON
);
  // capture state and pending first part
  mapc_state_e state_reg, state_next;
  mapc_cmd_e pend_kind_reg, pend_kind_next;
  logic [2:0] pend_bank_reg, pend_bank_next;
  logic [21:0] ax_reg, ax_next;
  logic bank_refresh_cmd_pend_reg, bank_refresh_cmd_pend_next;
  mapc_cmd_s cmd_reg, cmd_next;
  // mode register fields
  logic mux_reg, mux_next;
  logic [2:0] cfg_reg, cfg_next;
  mapc_bl_e bl_reg, bl_next;
  logic dll_off_reg, dll_off_next;
  logic imp_reg, imp_next;
  logic odt_reg, odt_next;
  logic reject_reg, reject_next;
  mapc_timing_s timing_reg, timing_next;
  // strap capture after reset release
  mapc_width_e width_reg, width_next;
  logic strap_done_reg, strap_done_next;
  // pin decode
  logic cmd_seen;
  mapc_cmd_e pin_kind;
  logic [21:0] merged_addr;
  // first part: balls carry their own bit numbers
  function automatic logic [21:0] first_part(input logic [21:0] b, input mapc_width_e w,
                                             input mapc_bl_e bl);
    logic [21:0] a;
    a = '0;
    a[`MAPC_BALL_0] = b[`MAPC_BALL_0];
    a[`MAPC_BALL_3] = b[`MAPC_BALL_3];
    a[`MAPC_BALL_4] = b[`MAPC_BALL_4];
    a[`MAPC_BALL_5] = b[`MAPC_BALL_5];
    a[`MAPC_BALL_8] = b[`MAPC_BALL_8];
    a[`MAPC_BALL_9] = b[`MAPC_BALL_9];
    a[`MAPC_BALL_10] = b[`MAPC_BALL_10];
    a[`MAPC_BALL_13] = b[`MAPC_BALL_13];
    a[`MAPC_BALL_14] = b[`MAPC_BALL_14];
    a[`MAPC_BALL_17] = b[`MAPC_BALL_17];
    // x36 burst eight has no use for ball A18
    if (!(w == MAPC_W_X36 && bl == MAPC_BL_8)) begin
      a[`MAPC_BALL_18] = b[`MAPC_BALL_18];
    end
    return a;
  endfunction
  // second part: balls carry the remaining bits, merged onto the first
  function automatic logic [21:0] second_part(input logic [21:0] ax, input logic [21:0] b,
                                              input mapc_width_e w, input mapc_bl_e bl);
    logic [21:0] a;
    a = ax;
    a[`MAPC_BIT_1] = b[`MAPC_BALL_3];
    a[`MAPC_BIT_2] = b[`MAPC_BALL_4];
    a[`MAPC_BIT_6] = b[`MAPC_BALL_8];
    a[`MAPC_BIT_7] = b[`MAPC_BALL_9];
    a[`MAPC_BIT_11] = b[`MAPC_BALL_13];
    a[`MAPC_BIT_12] = b[`MAPC_BALL_14];
    a[`MAPC_BIT_16] = b[`MAPC_BALL_17];
    a[`MAPC_BIT_15] = b[`MAPC_BALL_18];
    // ball A0 carries A20 for x9 bursts two and four, x18 burst two
    if ((w == MAPC_W_X9 && bl != MAPC_BL_8) || (w == MAPC_W_X18 && bl == MAPC_BL_2)) begin
      a[`MAPC_BIT_20] = b[`MAPC_BALL_0];
    end
    // ball A5 carries A21 only for x9 burst two
    if (w == MAPC_W_X9 && bl == MAPC_BL_2) begin
      a[`MAPC_BIT_21] = b[`MAPC_BALL_5];
    end
    // ball A10 carries A19 where the array needs it
    if ((w == MAPC_W_X9) || (w == MAPC_W_X18 && bl != MAPC_BL_8) ||
        (w == MAPC_W_X36 && bl == MAPC_BL_2)) begin
      a[`MAPC_BIT_19] = b[`MAPC_BALL_10];
    end
    return a;
  endfunction
  // command decode from the pins
  always_comb begin
    cmd_seen = !CS_N;
    case ({WE_N, REF_N})
      2'b11: pin_kind = MAPC_CMD_READ;
      2'b01: pin_kind = MAPC_CMD_WRITE;
      2'b10: pin_kind = MAPC_CMD_REFRESH;
      default: pin_kind = MAPC_CMD_MODE;
    endcase
    merged_addr = second_part(ax_reg, ADDR_BALL, width_reg, bl_reg);
  end
  // strap next value: caught once after reset release
  always_comb begin
    width_next = width_reg;
    strap_done_next = 1'b1;
    if (!strap_done_reg) begin
      case (WIDTH_STRAP)
        2'h1: width_next = MAPC_W_X18;
        2'h2: width_next = MAPC_W_X36;
        default: width_next = MAPC_W_X9;
      endcase
    end
  end
  // strap registers
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      width_reg <= MAPC_W_X9;
      strap_done_reg <= 1'b0;
    end else begin
      width_reg <= width_next;
      strap_done_reg <= strap_done_next;
    end
  end
  // capture machine and mode register next values
  always_comb begin
    logic mode_load;
    logic [21:0] mode_addr;
    logic [2:0] cfg_sel;
    mapc_bl_e bl_sel;
    logic [3:0] rc;
    mode_load = 1'b0;
    mode_addr = '0;
    cfg_sel = cfg_reg;
    bl_sel = bl_reg;
    rc = `MAPC_RC_CFG1;
    state_next = state_reg;
    pend_kind_next = pend_kind_reg;
    pend_bank_next = pend_bank_reg;
    ax_next = ax_reg;
    bank_refresh_cmd_pend_next = 1'b0;
    cmd_next = '0;
    mux_next = mux_reg;
    cfg_next = cfg_reg;
    bl_next = bl_reg;
    dll_off_next = dll_off_reg;
    imp_next = imp_reg;
    odt_next = odt_reg;
    reject_next = reject_reg;
    // a refresh seen last cycle executes now, no second part
    if (bank_refresh_cmd_pend_reg) begin
      cmd_next = '{1'b1, MAPC_CMD_REFRESH, pend_bank_reg, 22'h0};
    end
    case (state_reg)
      MAPC_ST_IDLE: begin
        if (cmd_seen && !mux_reg) begin
          // single-part capture issues on this edge
          if (pin_kind == MAPC_CMD_MODE) begin
            mode_load = 1'b1;
            mode_addr = ADDR_BALL;
          end else begin
            cmd_next = '{1'b1, pin_kind, BANK_SEL, ADDR_BALL};
          end
        end else if (cmd_seen) begin
          pend_bank_next = BANK_SEL;
          if (pin_kind == MAPC_CMD_REFRESH) begin
            // bank only: stay ready for the next clock
            bank_refresh_cmd_pend_next = 1'b1;
          end else begin
            pend_kind_next = pin_kind;
            ax_next = first_part(ADDR_BALL, width_reg, bl_reg);
            state_next = MAPC_ST_SECOND;
          end
        end
      end
      MAPC_ST_SECOND: begin
        // command pins are not looked at during the second part
        state_next = MAPC_ST_IDLE;
        if (pend_kind_reg == MAPC_CMD_MODE) begin
          mode_load = 1'b1;
          mode_addr = merged_addr;
        end else begin
          cmd_next = '{1'b1, pend_kind_reg, pend_bank_reg, merged_addr};
        end
      end
      default: state_next = MAPC_ST_IDLE;
    endcase
    // mode register write; bank inputs play no part
    if (mode_load) begin
      cfg_sel = mode_addr[`MAPC_MR_CFG_LSB +: 3];
      case (mode_addr[`MAPC_MR_BL_LSB +: 2])
        2'h1: bl_sel = MAPC_BL_4;
        2'h2: bl_sel = MAPC_BL_8;
        default: bl_sel = MAPC_BL_2;
      endcase
      // A5 high switches to two-part capture; never back
      mux_next = mux_reg | mode_addr[`MAPC_MR_MUX_BIT];
      dll_off_next = mode_addr[`MAPC_MR_DLL_BIT];
      imp_next = mode_addr[`MAPC_MR_IMP_BIT];
      odt_next = mode_addr[`MAPC_MR_ODT_BIT];
      cfg_next = cfg_sel;
      // burst eight is not offered with the shortest row cycles
      if (bl_sel == MAPC_BL_8 && (cfg_sel == 3'h1 || cfg_sel == 3'h4 || cfg_sel == 3'h0 ||
          cfg_sel > 3'h5)) begin
        reject_next = 1'b1;
        // a kept burst eight must never meet a short row cycle
        cfg_next = (bl_reg == MAPC_BL_8) ? cfg_reg : cfg_sel;
      end else begin
        reject_next = 1'b0;
        bl_next = bl_sel;
      end
    end
    // latency table from the configuration field
    case (cfg_next)
      3'h2: rc = `MAPC_RC_CFG2;
      3'h3: rc = `MAPC_RC_CFG3;
      3'h4: rc = `MAPC_RC_CFG4;
      3'h5: rc = `MAPC_RC_CFG5;
      default: rc = `MAPC_RC_CFG1;
    endcase
    timing_next.config_sel = cfg_next;
    timing_next.burst_length = bl_next;
    timing_next.row_cycle_time = rc;
    timing_next.read_latency_clocks = rc + `MAPC_RL_OVER_RC + (mux_next ? `MAPC_MUX_EXTRA : 4'h0);
    timing_next.write_latency_clocks = timing_next.read_latency_clocks + `MAPC_WL_OVER_RL;
  end
  // capture and mode registers
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= MAPC_ST_IDLE;
      pend_kind_reg <= MAPC_CMD_READ;
      pend_bank_reg <= 3'h0;
      ax_reg <= 22'h0;
      bank_refresh_cmd_pend_reg <= 1'b0;
      cmd_reg <= '0;
      mux_reg <= `MAPC_BIT_RST;
      cfg_reg <= `MAPC_CFG_RST;
      bl_reg <= MAPC_BL_2;
      dll_off_reg <= `MAPC_BIT_RST;
      imp_reg <= `MAPC_BIT_RST;
      odt_reg <= `MAPC_BIT_RST;
      reject_reg <= `MAPC_BIT_RST;
      timing_reg <= '{`MAPC_CFG_RST, MAPC_BL_2, `MAPC_RC_CFG1, `MAPC_RC_CFG1,
                      `MAPC_RC_CFG1 + `MAPC_WL_OVER_RL};
    end else begin
      state_reg <= state_next;
      pend_kind_reg <= pend_kind_next;
      pend_bank_reg <= pend_bank_next;
      ax_reg <= ax_next;
      bank_refresh_cmd_pend_reg <= bank_refresh_cmd_pend_next;
      cmd_reg <= cmd_next;
      mux_reg <= mux_next;
      cfg_reg <= cfg_next;
      bl_reg <= bl_next;
      dll_off_reg <= dll_off_next;
      imp_reg <= imp_next;
      odt_reg <= odt_next;
      reject_reg <= reject_next;
      timing_reg <= timing_next;
    end
  end
  // outputs straight from registers
  assign CMD_OUT = cmd_reg;
  assign TIMING_OUT = timing_reg;
  assign MUX_MODE = mux_reg;
  assign DLL_OFF = dll_off_reg;
  assign BURST_REJECT = reject_reg;
  assign DRIVE_IMP = imp_reg;
  assign TERM_ON = odt_reg;
endmodule

/* mapc_port_properties.sv */
`timescale 1ns/1ps
module mapc_port_properties import mapc_pkg::*; (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // command pins
  input wire logic CS_N,
  input wire logic WE_N,
  input wire logic REF_N,
  input wire logic [2:0] BANK_SEL,
  input wire logic [21:0] ADDR_BALL,
  input wire logic [1:0] WIDTH_STRAP,
  // decoded outputs
  input wire mapc_cmd_s CMD_OUT,
  input wire mapc_timing_s TIMING_OUT,
  input wire logic MUX_MODE,
  input wire logic DLL_OFF,
  input wire logic BURST_REJECT,
  input wire logic DRIVE_IMP,
  input wire logic TERM_ON
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // high in a second-part cycle
  logic sec_reg;
  logic sec_next;
  // decodes at a first-part edge
  wire first_ok = !CS_N && !(MUX_MODE && sec_reg);
  wire is_rd = first_ok && WE_N && REF_N;
  wire is_ref = first_ok && WE_N && !REF_N;
  wire is_mode = first_ok && !WE_N && !REF_N;
  wire a5 = ADDR_BALL[5];
  wire a7 = ADDR_BALL[7];
  wire b13 = ADDR_BALL[13];
  wire mapc_bl_e bl_now = TIMING_OUT.burst_length;
  // two-part commands open a second-part cycle
  always_comb begin
    sec_next = MUX_MODE && first_ok && !is_ref;
  end
  // tracker register
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      sec_reg <= 1'b0;
    end else begin
      sec_reg <= sec_next;
    end
  end
  // row cycle clocks per configuration
  function automatic logic [3:0] rc_of(input logic [2:0] c);
    case (c)
      3'h2: rc_of = 4'h6;
      3'h3: rc_of = 4'h8;
      3'h4: rc_of = 4'h3;
      3'h5: rc_of = 4'h5;
      default: rc_of = 4'h4;
    endcase
  endfunction
  a_plain_read_out: assert property (!MUX_MODE && is_rd |=> CMD_OUT.valid &&
      CMD_OUT.kind == MAPC_CMD_READ && CMD_OUT.bank == $past(BANK_SEL) &&
      CMD_OUT.addr == $past(ADDR_BALL)) else $error("plain read output wrong");
  a_mux_enter: assert property (!MUX_MODE && is_mode && a5 |=> MUX_MODE)
    else $error("mux mode not entered");
  a_mux_sticky: assert property (MUX_MODE |=> MUX_MODE)
    else $error("mux mode dropped");
  a_mux_read_out: assert property (MUX_MODE && is_rd |=> ##1 CMD_OUT.valid &&
      CMD_OUT.kind == MAPC_CMD_READ && CMD_OUT.bank == $past(BANK_SEL, 2) &&
      CMD_OUT.addr[13] == $past(b13, 2) && CMD_OUT.addr[11] == $past(b13))
    else $error("mux read output wrong");
  a_mux_ref_out: assert property (MUX_MODE && is_ref |=> ##1 CMD_OUT.valid &&
      CMD_OUT.kind == MAPC_CMD_REFRESH && CMD_OUT.bank == $past(BANK_SEL, 2) &&
      CMD_OUT.addr == 22'h000000) else $error("mux refresh output wrong");
  a_mux_lat_plus: assert property (MUX_MODE && is_mode |=> ##1
      TIMING_OUT.read_latency_clocks == TIMING_OUT.row_cycle_time + 4'h1 &&
      TIMING_OUT.write_latency_clocks == TIMING_OUT.read_latency_clocks + 4'h1)
    else $error("mux latency wrong");
  a_rc_table: assert property (TIMING_OUT.row_cycle_time == rc_of(TIMING_OUT.config_sel))
    else $error("row cycle wrong");
  a_no_bl8_short: assert property (TIMING_OUT.config_sel inside {3'h1, 3'h4} |->
      bl_now != MAPC_BL_8) else $error("burst eight in short config");
  a_reject_keeps_bl: assert property ($rose(BURST_REJECT) |-> bl_now == $past(bl_now))
    else $error("refused burst changed");
  a_dll_follow: assert property (!MUX_MODE && is_mode |=> DLL_OFF == $past(a7) &&
      !CMD_OUT.valid) else $error("mode set result wrong");
  c_mux_ref: cover property (MUX_MODE && is_ref);
  c_mux_rd: cover property (MUX_MODE && is_rd);
  c_reject: cover property ($rose(BURST_REJECT));
endmodule
bind mapc_port mapc_port_properties u_props (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .CS_N(CS_N), .WE_N(WE_N), .REF_N(REF_N), .BANK_SEL(BANK_SEL), .ADDR_BALL(ADDR_BALL),
  .WIDTH_STRAP(WIDTH_STRAP), .CMD_OUT(CMD_OUT), .TIMING_OUT(TIMING_OUT),
  .MUX_MODE(MUX_MODE), .DLL_OFF(DLL_OFF), .BURST_REJECT(BURST_REJECT),
  .DRIVE_IMP(DRIVE_IMP), .TERM_ON(TERM_ON));

/* test_mapc_port.sv */
`timescale 1ns/1ps
module test_mapc_port import mapc_pkg::*;;
  localparam int SETTLE = 4; // settle cycles after the mux entry mode set
  localparam logic [21:0] P1 = 22'h3FFFFF; // first part, all ones
  localparam logic [21:0] P2 = 22'h024529; // second part, mixed bits
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] strap = 2'h0;
  wire cs_n, we_n, ref_n;
  wire [2:0] bank;
  wire [21:0] addr;
  mapc_cmd_s cmd;
  mapc_timing_s tim;
  logic mux, dll, rej, imp, term;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  mapc_ctrl_model u_ctrl (.clk(clk), .cs_n(cs_n), .we_n(we_n), .ref_n(ref_n),
    .bank(bank), .addr(addr));
  mapc_port u_dut (.CLK_SYS(clk), .RST_N(rst_n), .CS_N(cs_n), .WE_N(we_n), .REF_N(ref_n),
    .BANK_SEL(bank), .ADDR_BALL(addr), .WIDTH_STRAP(strap), .CMD_OUT(cmd),
    .TIMING_OUT(tim), .MUX_MODE(mux), .DLL_OFF(dll), .BURST_REJECT(rej),
    .DRIVE_IMP(imp), .TERM_ON(term));
  // verdict and end of run
  task automatic complete_run();
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  // counted comparison
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  // decoded command expected this cycle
  task automatic expect_cmd(input mapc_cmd_e k, input logic [2:0] b, input logic [21:0] a);
    check(cmd === mapc_cmd_s'({1'b1, k, b, a}), "command output mismatch");
  endtask
  // reset held six cycles with a width strap
  task automatic do_reset(input logic [1:0] w);
    @(negedge clk);
    rst_n <= 1'b0;
    strap <= w;
    repeat (6) @(negedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
  endtask
  // two-part mode set: config, burst, dll reset
  task automatic mux_mode(input logic [2:0] c, input logic [1:0] bl, input logic d);
    u_ctrl.issue(1'b0, 1'b0, 3'h7, {12'h000, 4'h0, 1'b1, bl, 2'h0, c[0]});
    u_ctrl.part2({12'h000, d, 3'h0, 1'b0, c[2:1], 3'h0});
    u_ctrl.rest(2);
  endtask
  // merged address per width and burst
  function automatic logic [21:0] exp_map(input logic [1:0] w, input logic [1:0] bl);
    logic [21:0] e;
    e = P1 & 22'h066739;
    if (w == 2'h2 && bl == 2'h2) e[18] = 1'b0;
    e[2:1] = P2[4:3];
    e[7:6] = P2[9:8];
    e[12:11] = P2[14:13];
    e[16:15] = {P2[17], P2[18]};
    if ((w == 2'h0 && bl != 2'h2) || (w == 2'h1 && bl == 2'h0)) e[20] = P2[0];
    if (w == 2'h0 && bl == 2'h0) e[21] = P2[5];
    if (w == 2'h0 || (w == 2'h1 && bl != 2'h2) || (w == 2'h2 && bl == 2'h0)) e[19] = P2[10];
    return e;
  endfunction
  // outputs after reset
  task automatic t_reset_values();
    check(tim === mapc_timing_s'({3'h1, MAPC_BL_2, 4'h4, 4'h4, 4'h5}), "timing reset");
    check({cmd, mux, dll, rej, imp, term} === '0, "status reset");
  endtask
  // single-part commands back to back, then a plain mode set
  task automatic t_plain();
    u_ctrl.issue(1'b1, 1'b1, 3'h2, 22'h2AAAAA);
    u_ctrl.issue(1'b0, 1'b1, 3'h5, 22'h155555);
    expect_cmd(MAPC_CMD_READ, 3'h2, 22'h2AAAAA);
    u_ctrl.issue(1'b1, 1'b0, 3'h6, 22'h000000);
    expect_cmd(MAPC_CMD_WRITE, 3'h5, 22'h155555);
    u_ctrl.rest(1);
    expect_cmd(MAPC_CMD_REFRESH, 3'h6, 22'h000000);
    u_ctrl.issue(1'b0, 1'b0, 3'h3, {12'h000, 3'h7, 2'h0, 2'h1, 3'h2});
    u_ctrl.rest(2);
    check({dll, imp, term, mux} === 4'hE, "plain mode bits");
    check(tim === mapc_timing_s'({3'h2, MAPC_BL_4, 4'h6, 4'h6, 4'h7}), "plain timing");
  endtask
  // reset, enter mux mode, initial refreshes
  task automatic t_enter(input logic [1:0] w);
    do_reset(w);
    check(mux === 1'b0, "mux after reset");
    u_ctrl.issue(1'b0, 1'b0, 3'h0, 22'h000020);
    u_ctrl.rest(SETTLE);
    check(mux === 1'b1, "mux entry");
    mux_mode(3'h2, 2'h0, 1'b0);
    for (int b = 0; b < 8; b++) begin
      u_ctrl.issue(1'b1, 1'b0, b[2:0], 22'h000000);
      u_ctrl.rest(128);
    end
  endtask
  // refresh then read, then write, per burst
  task automatic t_map(input logic [1:0] w);
    for (int bl = 0; bl < 3; bl++) begin
      mux_mode(3'h2, bl[1:0], 1'b0);
      u_ctrl.issue(1'b1, 1'b0, 3'h5, P1);
      u_ctrl.issue(1'b1, 1'b1, 3'h1, P1);
      u_ctrl.part2(P2);
      expect_cmd(MAPC_CMD_REFRESH, 3'h5, 22'h000000);
      u_ctrl.issue(1'b0, 1'b1, 3'h2, P1);
      expect_cmd(MAPC_CMD_READ, 3'h1, exp_map(w, bl[1:0]));
      u_ctrl.part2(P2);
      u_ctrl.rest(1);
      expect_cmd(MAPC_CMD_WRITE, 3'h2, exp_map(w, bl[1:0]));
    end
  endtask
  // every configuration in mux mode
  task automatic t_latency();
    logic [3:0] rc [5] = '{4'h4, 4'h6, 4'h8, 4'h3, 4'h5};
    for (int c = 1; c < 6; c++) begin
      mux_mode(c[2:0], 2'h0, 1'b1);
      check(tim === mapc_timing_s'({c[2:0], MAPC_BL_2, rc[c - 1],
          rc[c - 1] + 4'h1, rc[c - 1] + 4'h2}), "config timing");
      check(dll === 1'b1, "dll reset bit");
    end
  endtask
  // burst eight refused in short configs only
  task automatic t_reject();
    mux_mode(3'h1, 2'h1, 1'b0);
    mux_mode(3'h1, 2'h2, 1'b0);
    check({rej, tim.burst_length} === {1'b1, MAPC_BL_4}, "cfg1 burst eight");
    mux_mode(3'h4, 2'h2, 1'b0);
    check({rej, tim.burst_length} === {1'b1, MAPC_BL_4}, "cfg4 burst eight");
    // same-bank write then read, four clocks apart, in the three-cycle configuration
    u_ctrl.issue(1'b0, 1'b1, 3'h3, P1);
    u_ctrl.part2(P2);
    u_ctrl.rest(1);
    expect_cmd(MAPC_CMD_WRITE, 3'h3, exp_map(2'h2, 2'h1));
    u_ctrl.rest(1);
    u_ctrl.issue(1'b1, 1'b1, 3'h3, P1);
    u_ctrl.part2(P2);
    u_ctrl.rest(1);
    expect_cmd(MAPC_CMD_READ, 3'h3, exp_map(2'h2, 2'h1));
    mux_mode(3'h2, 2'h2, 1'b0);
    check({rej, tim.burst_length} === {1'b0, MAPC_BL_8}, "cfg2 burst eight");
    // a short configuration asked while burst eight stands is refused whole
    mux_mode(3'h1, 2'h2, 1'b0);
    check({rej, tim.config_sel, tim.burst_length} === {1'b1, 3'h2, MAPC_BL_8},
        "short config kept burst eight");
  endtask
  // main sequence
  initial begin
    do_reset(2'h0);
    t_reset_values();
    t_plain();
    for (int w = 0; w < 3; w++) begin
      t_enter(w[1:0]);
      t_map(w[1:0]);
    end
    t_latency();
    t_reject();
    complete_run();
  end
endmodule
